// File: logic/dpsui_pkg.sv
package dpsui_pkg;

    // Timing base
    localparam longint unsigned CLK_HZ       = 200_000_000;
    localparam longint unsigned DEBOUNCE_MS  = 10;
    localparam longint unsigned HOLD_S       = 3;
    localparam longint unsigned SHOW_S       = 15;
    localparam longint unsigned CONFIRM_S    = 10;
    localparam longint unsigned ACK_MS       = 2000;
    localparam longint unsigned BLINK_MS     = 250;

    localparam logic [31:0] DEBOUNCE_CYC = 32'(CLK_HZ * DEBOUNCE_MS / 1000);
    localparam logic [31:0] HOLD_CYC     = 32'(CLK_HZ * HOLD_S);
    localparam logic [31:0] SHOW_CYC     = 32'(CLK_HZ * SHOW_S);
    localparam logic [31:0] CONFIRM_CYC  = 32'(CLK_HZ * CONFIRM_S);
    localparam logic [31:0] ACK_CYC      = 32'(CLK_HZ * ACK_MS / 1000);
    localparam logic [31:0] BLINK_CYC    = 32'(CLK_HZ * BLINK_MS / 1000);

    // Button indices
    localparam int NBTN     = 5;
    localparam int BTN_TEST = 0;
    localparam int BTN_SET  = 1;
    localparam int BTN_DOWN = 2;
    localparam int BTN_UP   = 3;
    localparam int BTN_PWR  = 4;

    // Register map
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_SETPT  = 12'h008;
    localparam int          CTRL_LOCK   = 0;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
    localparam int          ST_UNIT_ON  = 0;
    localparam int          ST_STATE_LO = 4;
    localparam int          ST_LAMP_LO  = 8;
    localparam int          SP_PEND_LO  = 8;

    // Set-point range
    localparam logic signed [7:0] SP_RESET = 8'sh25;
    localparam logic signed [7:0] SP_MIN   = 8'sh21;
    localparam logic signed [7:0] SP_MAX   = 8'sh30;
    localparam logic signed [7:0] SP_STEP  = 8'sh01;

    typedef enum logic [1:0] {
        DISP_DEW     = 2'h0,
        DISP_SETPT   = 2'h1,
        DISP_STANDBY = 2'h2,
        DISP_OFF     = 2'h3
    } dpsui_disp_e;

    typedef enum logic [3:0] {
        S_NORMAL = 4'h1,
        S_SHOW   = 4'h2,
        S_EDIT   = 4'h4,
        S_ACK    = 4'h8
    } dpsui_state_e;

endpackage

// File: logic/dpsui_panel.sv
// Notes on behaviour
// - Lamps follow expansion, drain, compressor actuators
// - Drain test only after test held 3 s
// - Set in normal operation shows set-point
// - Set after changing value commits pending value
// - Down steps displayed value one lower
// - Up steps displayed value one higher
// - Power held 3 s toggles unit state
// - Deactivated unit shows off message
// - No adjustment in 15 s returns normal
// - Normal display shows steady dewpoint value
// - Confirm within 10 s stores, flashes set-point
// - Unconfirmed after 10 s discards pending value
// - Standby shows steady standby code
// - Field lock allows viewing, blocks adjustment
// - Ice-melt cooling selects the standby code
//
// Register access over APB and the register offsets were left to the implementer.
module dpsui_panel #(
    parameter logic [31:0] DEBOUNCE_CYC = dpsui_pkg::DEBOUNCE_CYC,
    parameter logic [31:0] HOLD_CYC     = dpsui_pkg::HOLD_CYC,
    parameter logic [31:0] SHOW_CYC     = dpsui_pkg::SHOW_CYC,
    parameter logic [31:0] CONFIRM_CYC  = dpsui_pkg::CONFIRM_CYC,
    parameter logic [31:0] ACK_CYC      = dpsui_pkg::ACK_CYC,
    parameter logic [31:0] BLINK_CYC    = dpsui_pkg::BLINK_CYC
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic [31:0]                 prdata,
    // Pushbuttons, active high
    input  wire logic                   btn_test,
    input  wire logic                   btn_set,
    input  wire logic                   btn_down,
    input  wire logic                   btn_up,
    input  wire logic                   btn_power,
    // Control loop state
    input  wire logic                   direct_expansion,
    input  wire logic                   drain_valve_on,
    input  wire logic                   compressor_on,
    input  wire logic                   ice_melt_active,
    input  wire logic signed [7:0]      dewpoint,
    // Lamps and control loop requests
    output logic                        expansion_valve_lamp,
    output logic                        drain_valve_lamp,
    output logic                        compressor_lamp,
    output logic                        drain_test,
    output logic                        unit_on,
    output logic signed [7:0]           setpoint,
    // Display
    output dpsui_pkg::dpsui_disp_e      disp_sel,
    output logic signed [7:0]           disp_value,
    output logic                        disp_blank
);

    localparam int NB = dpsui_pkg::NBTN;

    logic [NB-1:0] raw;
    logic [NB-1:0] press;
    logic [NB-1:0] held;

    assign raw = {btn_power, btn_up, btn_down, btn_set, btn_test};

    // Per-button debounce and hold qualification
    for (genvar i = 0; i < NB; i++)
    begin : g_btn
        logic [31:0] db_cnt_r;
        logic [31:0] db_cnt_nxt;
        logic [31:0] hold_r;
        logic [31:0] hold_nxt;
        logic        stable_r;
        logic        stable_nxt;

        always_comb
        begin
            db_cnt_nxt = 32'h0000_0000;
            stable_nxt = stable_r;
            hold_nxt   = hold_r;
            if (raw[i] != stable_r)
            begin
                db_cnt_nxt = db_cnt_r + 32'h0000_0001;
                if (db_cnt_r >= DEBOUNCE_CYC - 32'h0000_0001)
                begin
                    stable_nxt = raw[i];
                    db_cnt_nxt = 32'h0000_0000;
                end
            end
            // Saturates so the hold fires once per press
            if (!stable_r)
                hold_nxt = 32'h0000_0000;
            else if (hold_r < HOLD_CYC)
                hold_nxt = hold_r + 32'h0000_0001;
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                db_cnt_r <= 32'h0000_0000;
                stable_r <= 1'b0;
                hold_r   <= 32'h0000_0000;
            end
            else
            begin
                db_cnt_r <= db_cnt_nxt;
                stable_r <= stable_nxt;
                hold_r   <= hold_nxt;
            end
        end

        assign press[i] = stable_nxt && !stable_r;
        assign held[i]  = stable_r && (hold_r == HOLD_CYC - 32'h0000_0001);
    end

    // Control registers
    logic                       lock_r;
    logic                       lock_nxt;
    logic [31:0]                prdata_r;
    logic [31:0]                prdata_nxt;
    logic                       addr_ok;

    // Panel state
    dpsui_pkg::dpsui_state_e    state_r;
    dpsui_pkg::dpsui_state_e    state_nxt;
    logic [31:0]                timer_r;
    logic [31:0]                timer_nxt;
    logic [31:0]                blink_cnt_r;
    logic [31:0]                blink_cnt_nxt;
    logic                       blink_r;
    logic                       blink_nxt;
    logic                       unit_on_r;
    logic                       unit_on_nxt;
    logic signed [7:0]          stored_r;
    logic signed [7:0]          stored_nxt;
    logic signed [7:0]          pending_r;
    logic signed [7:0]          pending_nxt;
    logic                       test_r;
    logic                       test_nxt;
    logic [2:0]                 lamp_r;
    logic [2:0]                 lamp_nxt;
    dpsui_pkg::dpsui_disp_e     sel_r;
    dpsui_pkg::dpsui_disp_e     sel_nxt;
    logic signed [7:0]          val_r;
    logic signed [7:0]          val_nxt;
    logic                       blank_r;
    logic                       blank_nxt;
    logic                       adj_dn;
    logic                       adj_up;

    // Field lock blocks every adjustment; viewing stays allowed
    assign adj_dn = press[dpsui_pkg::BTN_DOWN] && !lock_r;
    assign adj_up = press[dpsui_pkg::BTN_UP] && !lock_r;

    always_comb
    begin
        state_nxt   = state_r;
        timer_nxt   = timer_r + 32'h0000_0001;
        unit_on_nxt = unit_on_r;
        stored_nxt  = stored_r;
        pending_nxt = pending_r;
        test_nxt    = 1'b0;
        if (held[dpsui_pkg::BTN_PWR])
            unit_on_nxt = !unit_on_r;
        if (!unit_on_r)
        begin
            state_nxt = dpsui_pkg::S_NORMAL;
            timer_nxt = 32'h0000_0000;
        end
        else
        begin
            unique case (state_r)
                dpsui_pkg::S_NORMAL:
                begin
                    test_nxt  = held[dpsui_pkg::BTN_TEST];
                    timer_nxt = 32'h0000_0000;
                    if (press[dpsui_pkg::BTN_SET])
                        state_nxt = dpsui_pkg::S_SHOW;
                end
                dpsui_pkg::S_SHOW:
                begin
                    if (adj_dn || adj_up)
                    begin
                        state_nxt   = dpsui_pkg::S_EDIT;
                        timer_nxt   = 32'h0000_0000;
                        pending_nxt = stored_r;
                    end
                    else if (press[dpsui_pkg::BTN_SET] || timer_r >= SHOW_CYC - 32'h0000_0001)
                        state_nxt = dpsui_pkg::S_NORMAL;
                end
                dpsui_pkg::S_EDIT:
                begin
                    if (press[dpsui_pkg::BTN_SET])
                    begin
                        stored_nxt = pending_r;
                        state_nxt  = dpsui_pkg::S_ACK;
                        timer_nxt  = 32'h0000_0000;
                    end
                    else if (adj_dn || adj_up)
                        timer_nxt = 32'h0000_0000;
                    else if (timer_r >= CONFIRM_CYC - 32'h0000_0001)
                        state_nxt = dpsui_pkg::S_NORMAL;
                end
                dpsui_pkg::S_ACK:
                begin
                    if (timer_r >= ACK_CYC - 32'h0000_0001)
                        state_nxt = dpsui_pkg::S_NORMAL;
                end
            endcase
        end
        // Step from the stored value on the first adjustment
        if (state_r == dpsui_pkg::S_SHOW || state_r == dpsui_pkg::S_EDIT)
        begin
            if (adj_dn && pending_nxt > dpsui_pkg::SP_MIN)
                pending_nxt = pending_nxt - dpsui_pkg::SP_STEP;
            else if (adj_up && pending_nxt < dpsui_pkg::SP_MAX)
                pending_nxt = pending_nxt + dpsui_pkg::SP_STEP;
        end
    end

    // Display selection and acknowledge flashing
    always_comb
    begin
        lamp_nxt      = {compressor_on, drain_valve_on, direct_expansion};
        blink_cnt_nxt = 32'h0000_0000;
        blink_nxt     = 1'b0;
        blank_nxt     = 1'b0;
        if (state_nxt == dpsui_pkg::S_ACK)
        begin
            blink_cnt_nxt = blink_cnt_r + 32'h0000_0001;
            blink_nxt     = blink_r;
            if (blink_cnt_r >= BLINK_CYC - 32'h0000_0001)
            begin
                blink_cnt_nxt = 32'h0000_0000;
                blink_nxt     = !blink_r;
            end
        end
        if (!unit_on_nxt)
        begin
            sel_nxt = dpsui_pkg::DISP_OFF;
            val_nxt = 8'sh00;
        end
        else if (state_nxt == dpsui_pkg::S_EDIT)
        begin
            sel_nxt = dpsui_pkg::DISP_SETPT;
            val_nxt = pending_nxt;
        end
        else if (state_nxt != dpsui_pkg::S_NORMAL)
        begin
            sel_nxt   = dpsui_pkg::DISP_SETPT;
            val_nxt   = stored_nxt;
            blank_nxt = blink_nxt;
        end
        else if (ice_melt_active)
        begin
            sel_nxt = dpsui_pkg::DISP_STANDBY;
            val_nxt = 8'sh00;
        end
        else
        begin
            sel_nxt = dpsui_pkg::DISP_DEW;
            val_nxt = dewpoint;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r     <= dpsui_pkg::S_NORMAL;
            timer_r     <= 32'h0000_0000;
            blink_cnt_r <= 32'h0000_0000;
            blink_r     <= 1'b0;
            unit_on_r   <= 1'b0;
            stored_r    <= dpsui_pkg::SP_RESET;
            pending_r   <= dpsui_pkg::SP_RESET;
            test_r      <= 1'b0;
            lamp_r      <= 3'h0;
            sel_r       <= dpsui_pkg::DISP_OFF;
            val_r       <= 8'sh00;
            blank_r     <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            timer_r     <= timer_nxt;
            blink_cnt_r <= blink_cnt_nxt;
            blink_r     <= blink_nxt;
            unit_on_r   <= unit_on_nxt;
            stored_r    <= stored_nxt;
            pending_r   <= pending_nxt;
            test_r      <= test_nxt;
            lamp_r      <= lamp_nxt;
            sel_r       <= sel_nxt;
            val_r       <= val_nxt;
            blank_r     <= blank_nxt;
        end
    end

    // APB slave, zero wait states; read data captured in the setup cycle
    always_comb
    begin
        lock_nxt   = lock_r;
        prdata_nxt = prdata_r;
        addr_ok    = (paddr == dpsui_pkg::ADDR_CTRL) || (paddr == dpsui_pkg::ADDR_STATUS)
                     || (paddr == dpsui_pkg::ADDR_SETPT);
        if (psel && penable && pwrite && paddr == dpsui_pkg::ADDR_CTRL)
            lock_nxt = pwdata[dpsui_pkg::CTRL_LOCK];
        if (psel && !penable)
        begin
            prdata_nxt = 32'h0000_0000;
            unique case (paddr)
                dpsui_pkg::ADDR_CTRL:
                    prdata_nxt[dpsui_pkg::CTRL_LOCK] = lock_r;
                dpsui_pkg::ADDR_STATUS:
                begin
                    prdata_nxt[dpsui_pkg::ST_UNIT_ON] = unit_on_r;
                    prdata_nxt[dpsui_pkg::ST_STATE_LO +: 4] = state_r;
                    prdata_nxt[dpsui_pkg::ST_LAMP_LO +: 3] = lamp_r;
                end
                dpsui_pkg::ADDR_SETPT:
                begin
                    prdata_nxt[7:0] = stored_r;
                    prdata_nxt[dpsui_pkg::SP_PEND_LO +: 8] = pending_r;
                end
                default:
                    prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_r   <= dpsui_pkg::CTRL_RESET[dpsui_pkg::CTRL_LOCK];
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            lock_r   <= lock_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign pready               = 1'b1;
    assign pslverr              = psel && penable && !addr_ok;
    assign prdata               = prdata_r;
    assign expansion_valve_lamp = lamp_r[0];
    assign drain_valve_lamp     = lamp_r[1];
    assign compressor_lamp      = lamp_r[2];
    assign drain_test           = test_r;
    assign unit_on              = unit_on_r;
    assign setpoint             = stored_r;
    assign disp_sel             = sel_r;
    assign disp_value           = val_r;
    assign disp_blank           = blank_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_lamps;
        ##1 (expansion_valve_lamp == $past(direct_expansion)) && (compressor_lamp == $past(compressor_on))
            && (drain_valve_lamp == $past(drain_valve_on));
    endproperty
    a_lamps: assert property (p_lamps) else $error("lamp does not follow actuator");

    property p_test;
        drain_test |-> $past(held[dpsui_pkg::BTN_TEST]) && $past(unit_on_r)
                       && $past(state_r) == dpsui_pkg::S_NORMAL;
    endproperty
    a_test: assert property (p_test) else $error("drain test without qualified hold");

    property p_show;
        unit_on_r && state_r == dpsui_pkg::S_NORMAL && press[dpsui_pkg::BTN_SET] && !held[dpsui_pkg::BTN_PWR]
            |=> disp_sel == dpsui_pkg::DISP_SETPT && disp_value == stored_r;
    endproperty
    a_show: assert property (p_show) else $error("set press did not show set-point");

    property p_commit;
        unit_on_r && state_r == dpsui_pkg::S_EDIT && press[dpsui_pkg::BTN_SET]
            |=> setpoint == $past(pending_r) && state_r == dpsui_pkg::S_ACK;
    endproperty
    a_commit: assert property (p_commit) else $error("confirm did not store value");

    property p_down;
        unit_on_r && state_r == dpsui_pkg::S_EDIT && adj_dn && !press[dpsui_pkg::BTN_SET]
            && pending_r > dpsui_pkg::SP_MIN |=> pending_r == $past(pending_r) - dpsui_pkg::SP_STEP;
    endproperty
    a_down: assert property (p_down) else $error("down press did not step");

    property p_up;
        unit_on_r && state_r == dpsui_pkg::S_EDIT && adj_up && !adj_dn && !press[dpsui_pkg::BTN_SET]
            && pending_r < dpsui_pkg::SP_MAX |=> pending_r == $past(pending_r) + dpsui_pkg::SP_STEP;
    endproperty
    a_up: assert property (p_up) else $error("up press did not step");

    property p_power;
        $changed(unit_on_r) |-> $past(held[dpsui_pkg::BTN_PWR]);
    endproperty
    a_power: assert property (p_power) else $error("unit toggled without power hold");

    property p_off;
        !unit_on_r ##1 !unit_on_r |-> disp_sel == dpsui_pkg::DISP_OFF;
    endproperty
    a_off: assert property (p_off) else $error("off message missing");

    property p_discard;
        unit_on_r && state_r == dpsui_pkg::S_EDIT && !press[dpsui_pkg::BTN_SET]
            |=> setpoint == $past(stored_r);
    endproperty
    a_discard: assert property (p_discard) else $error("set-point changed without confirm");

    property p_standby;
        unit_on_r && state_r == dpsui_pkg::S_NORMAL && ice_melt_active && !press[dpsui_pkg::BTN_SET] ##1 unit_on_r
            |-> disp_sel == dpsui_pkg::DISP_STANDBY && !disp_blank;
    endproperty
    a_standby: assert property (p_standby) else $error("standby code not steady");

    property p_lock;
        lock_r && state_r != dpsui_pkg::S_EDIT |=> state_r != dpsui_pkg::S_EDIT;
    endproperty
    a_lock: assert property (p_lock) else $error("adjustment entered while locked");

    property p_once;
        held[dpsui_pkg::BTN_PWR] |=> !held[dpsui_pkg::BTN_PWR] [*2];
    endproperty
    a_once: assert property (p_once) else $error("hold action repeated");

    c_edit:    cover property (state_r == dpsui_pkg::S_EDIT ##1 state_r == dpsui_pkg::S_ACK);
    c_timeout: cover property (state_r == dpsui_pkg::S_SHOW ##1 state_r == dpsui_pkg::S_NORMAL);
    c_test:    cover property (drain_test);
    c_poweron: cover property ($rose(unit_on_r));

endmodule // dpsui_panel

// File: verification/dpsui_operator.sv
// Operator at the panel: one button held for a set count, then a quiet gap
module dpsui_operator (
    // Clock
    input  wire logic        pclk,
    // Press request
    input  wire logic        press_go,
    input  wire logic [2:0]  press_idx,
    input  wire logic [15:0] press_len,
    output logic             press_busy,
    // Buttons, active high
    output logic [4:0]       btn
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] cnt_r = 16'h0000;
    logic [2:0]  idx_r = 3'h0;

    initial press_busy = 1'b0;

    // Gap of 10 cycles outlasts the debounce, so every press is seen alone
    always @(posedge pclk)
    begin
        if (!press_busy && press_go)
        begin
            press_busy <= 1'b1;
            idx_r      <= press_idx;
            cnt_r      <= press_len + 16'h000A;
        end
        else if (press_busy)
        begin
            cnt_r <= cnt_r - 16'h0001;
            if (cnt_r == 16'h0001)
                press_busy <= 1'b0;
        end
    end

    assign btn = (press_busy && cnt_r > 16'h000A) ? 5'(5'h01 << idx_r) : 5'h00;
endmodule // dpsui_operator

// File: verification/dpsui_panel_tb.sv
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module dpsui_panel_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, press_go = 1'b0, press_busy;
    logic [2:0] press_idx = 3'h0;
    logic [15:0] press_len = 16'h0000;
    logic [4:0] btn;
    logic dx = 1'b0, drv = 1'b0, cmp = 1'b0, ice = 1'b0;
    logic signed [7:0] dew = 8'sh26, setpoint, disp_value;
    logic lamp_x, lamp_d, lamp_c, drain_test, unit_on, disp_blank;
    dpsui_pkg::dpsui_disp_e disp_sel;
    int mismatches = 0, check_count = 0, pulses = 0, blanks = 0;

    dpsui_panel #(.DEBOUNCE_CYC(32'h4), .HOLD_CYC(32'h14), .SHOW_CYC(32'h3C), .CONFIRM_CYC(32'h28),
                  .ACK_CYC(32'h1E), .BLINK_CYC(32'h5)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .btn_test(btn[0]), .btn_set(btn[1]), .btn_down(btn[2]), .btn_up(btn[3]), .btn_power(btn[4]),
        .direct_expansion(dx), .drain_valve_on(drv), .compressor_on(cmp), .ice_melt_active(ice),
        .dewpoint(dew), .expansion_valve_lamp(lamp_x), .drain_valve_lamp(lamp_d),
        .compressor_lamp(lamp_c), .drain_test(drain_test), .unit_on(unit_on), .setpoint(setpoint),
        .disp_sel(disp_sel), .disp_value(disp_value), .disp_blank(disp_blank));

    dpsui_operator OPER (.pclk(pclk), .press_go(press_go), .press_idx(press_idx),
                         .press_len(press_len), .press_busy(press_busy), .btn(btn));

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (drain_test === 1'b1) pulses++;
        if (disp_blank === 1'b1) blanks++;
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic press(input logic [2:0] idx, input logic [15:0] len);
        @(posedge pclk);
        press_idx <= idx; press_len <= len; press_go <= 1'b1;
        @(posedge pclk);
        press_go <= 1'b0;
        do @(posedge pclk); while (press_busy);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("off display", dpsui_pkg::DISP_OFF, disp_sel)
        `CHK("reset setpoint", dpsui_pkg::SP_RESET, setpoint)
        apb(1'b0, dpsui_pkg::ADDR_CTRL, 32'h0);
        `CHK("ctrl reset", dpsui_pkg::CTRL_RESET, rd)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        press(3'h4, 16'h000C);
        `CHK("short power", 1'b0, unit_on)
        press(3'h4, 16'h003C);
        `CHK("long power once", 1'b1, unit_on)
        apb(1'b0, dpsui_pkg::ADDR_STATUS, 32'h0);
        `CHK("status", 8'h11, rd[7:0])
        dx <= 1'b1; cmp <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("lamps", 3'h5, {lamp_x, lamp_d, lamp_c})
        dx <= 1'b0; drv <= 1'b1;
        // New reading so the display cannot pass on the start value
        dew <= 8'sh1D;
        repeat (3) @(posedge pclk);
        `CHK("lamps", 3'h3, {lamp_x, lamp_d, lamp_c})
        `CHK("dew display", {dpsui_pkg::DISP_DEW, 8'h1D, 1'b0}, {disp_sel, disp_value, disp_blank})
        ice <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("standby", {dpsui_pkg::DISP_STANDBY, 1'b0}, {disp_sel, disp_blank})
        ice <= 1'b0;
        press(3'h0, 16'h000C);
        `CHK("short test", 0, pulses)
        press(3'h0, 16'h003C);
        `CHK("long test once", 1, pulses)
        // Bounce shorter than the debounce span
        press(3'h1, 16'h0002);
        `CHK("set glitch", dpsui_pkg::DISP_DEW, disp_sel)
        press(3'h1, 16'h0008);
        `CHK("show setpoint", {dpsui_pkg::DISP_SETPT, 8'h25}, {disp_sel, disp_value})
        press(3'h3, 16'h0008);
        `CHK("locked up", 8'h25, disp_value)
        repeat (50) @(posedge pclk);
        `CHK("show timeout", dpsui_pkg::DISP_DEW, disp_sel)
        apb(1'b1, dpsui_pkg::ADDR_CTRL, 32'h0);
        press(3'h1, 16'h0008);
        press(3'h3, 16'h0008);
        press(3'h3, 16'h0008);
        `CHK("up twice", 8'h27, disp_value)
        press(3'h2, 16'h0008);
        `CHK("down", 8'h26, disp_value)
        blanks = 0;
        press(3'h1, 16'h0008);
        `CHK("commit", 8'h26, setpoint)
        `CHK("flash", 1'b1, blanks > 0)
        repeat (40) @(posedge pclk);
        apb(1'b0, dpsui_pkg::ADDR_SETPT, 32'h0);
        `CHK("stored", 8'h26, rd[7:0])
        press(3'h1, 16'h0008);
        press(3'h3, 16'h0008);
        `CHK("pending", 8'h27, disp_value)
        repeat (50) @(posedge pclk);
        `CHK("discard", {dpsui_pkg::DISP_DEW, 8'h26}, {disp_sel, setpoint})
        press(3'h4, 16'h001E);
        `CHK("power off", {1'b0, dpsui_pkg::DISP_OFF}, {unit_on, disp_sel})
        tally_and_finish();
    end
endmodule // dpsui_panel_tb
